// ==== hdl/udc_counter.sv ====
// 16-bit up/down counter with timer output, register port and match pulses
// assumes: 100 MHz clock, async high reset, pins asynchronous to clock
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
module udc_counter
  import udc_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic [udc_pkg::ADDR_W-1:0] addr,
  input  wire logic [udc_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [udc_pkg::DATA_W-1:0] rdata,
  input  wire logic                       pulse_input,
  input  wire logic                       direction_input,
  input  wire logic                       external_clear_input,
  output logic                            timer_out_pin,
  output logic                            cycle_match_irq,
  output logic                            duty_match_irq,
  output logic                            capcomp_a_irq,
  output logic                            capcomp_b_irq
);

  // register file state
  logic [CTRL_W-1:0]  ctrl_q, ctrl_d;     // counter_control_reg
  logic [MODE_W-1:0]  mode_q, mode_d;     // counter_mode_reg
  logic [CNT_W-1:0]   cyc_q, cyc_d;       // cycle_compare
  logic [CNT_W-1:0]   duty_q, duty_d;     // duty_compare
  logic [CNT_W-1:0]   cca_q, cca_d;       // capcomp_a
  logic [CNT_W-1:0]   ccb_q, ccb_d;       // capcomp_b
  logic [DATA_W-1:0]  rdata_q, rdata_d;   // read data, one cycle after rd

  // counter state
  logic [CNT_W-1:0]   cnt_q, cnt_d;       // updown_counter
  logic [PRESC_W-1:0] pre_q, pre_d;       // prescaler
  logic               started_q, started_d; // first cycle done
  logic               out_q, out_d;       // timer output level
  logic               up_q, up_d;         // last count direction
  logic               cyc_irq_q, cyc_irq_d;
  logic               duty_irq_q, duty_irq_d;
  logic               cca_irq_q, cca_irq_d;
  logic               ccb_irq_q, ccb_irq_d;

  // synchronised pins: bit0 pulse, bit1 direction, bit2 clear
  logic [2:0]         pin_lvl, pin_rise, pin_fall; // level and edges

  // decoded configuration
  logic               ce;          // count_enable_bit
  logic               udc_mode;    // counting_mode_select
  logic               variant_b;   // variant_select
  logic               inv;         // output_level_invert, inactive level
  logic [2:0]         phase;       // phase_mode_reg
  logic [SEL_W-1:0]   sel;         // prescale select
  logic [PRESC_W:0]   mask9;       // prescaler terminal mask
  logic               tick;        // timer count clock enable
  logic               pv, dv;      // valid edges on pulse and direction
  logic               pa, da;      // any edge, for quadrature
  logic               ev;          // up/down count event
  logic               ev_up;       // direction of that event
  logic               cyc_hit, duty_hit; // counter equals cycle_compare, duty_compare
  logic               cca_hit, ccb_hit;  // compare-mode matches on capcomp_a, capcomp_b
  logic               ext_clr;     // external clear edge, enabled

  // pin synchroniser and edge detector
  udc_sync #(
    .W (3)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .din   ({external_clear_input, direction_input, pulse_input}),
    .lvl   (pin_lvl),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // configuration decode
  assign ce        = ctrl_q[CTRL_CE];
  assign udc_mode  = mode_q[MODE_UDC];
  assign variant_b = mode_q[MODE_VAR];
  assign inv       = mode_q[MODE_INV];
  assign phase     = mode_q[MODE_PH_LSB +: 3];
  assign sel       = ctrl_q[CTRL_SEL_LSB +: SEL_W];

  // prescaler tick every 4<<sel clocks; select 7 falls back to 256
  assign mask9 = (PRESC_BASE << sel) - 9'h001;
  assign tick  = (pre_q & mask9[PRESC_W-1:0]) == mask9[PRESC_W-1:0];

  // compare matches on the value held since the last count clock
  assign cyc_hit  = cnt_q == cyc_q;
  assign duty_hit = cnt_q == duty_q;
  assign cca_hit  = ctrl_q[CTRL_CCA_CMP] && (cnt_q == cca_q);
  assign ccb_hit  = ctrl_q[CTRL_CCB_CMP] && (cnt_q == ccb_q);

  // valid edges with selectable polarity
  assign pv = mode_q[MODE_PFALL] ? pin_fall[0] : pin_rise[0];
  assign dv = mode_q[MODE_DFALL] ? pin_fall[1] : pin_rise[1];
  assign pa = pin_rise[0] | pin_fall[0];
  assign da = pin_rise[1] | pin_fall[1];
  assign ext_clr = !variant_b && ctrl_q[CTRL_CLR_LO] && pin_rise[2];

  // phase decode into count event and direction
  always_comb begin
    ev    = 1'b0;
    ev_up = up_q;
    case (phase)
      PH_MODE1: begin
        ev    = pv;
        ev_up = ~pin_lvl[1];
      end
      PH_MODE2: begin
        ev    = pv ^ dv;
        ev_up = pv;
      end
      PH_MODE3: begin
        ev    = pv;
        ev_up = pin_lvl[1];
      end
      PH_MODE4: begin
        ev = pa | da;
        if (pa && da) begin
          ev_up = up_q;
        end else if (pa) begin
          ev_up = pin_lvl[0] ^ pin_lvl[1];
        end else begin
          ev_up = ~(pin_lvl[0] ^ pin_lvl[1]);
        end
      end
      default: ev = 1'b0;                             // no phase scheme chosen
    endcase
  end

  // counter, output and match pulse next values
  always_comb begin
    cnt_d      = cnt_q;
    pre_d      = pre_q;
    started_d  = started_q;
    out_d      = out_q;
    up_d       = up_q;
    cyc_irq_d  = 1'b0;
    duty_irq_d = 1'b0;
    cca_irq_d  = 1'b0;
    ccb_irq_d  = 1'b0;
    if (!ce) begin
      // stopped: counter parked, output inactive
      cnt_d     = CNT_RST;
      pre_d     = '0;
      started_d = 1'b0;
      out_d     = inv;
    end else if (!udc_mode) begin
      // general timer, internal prescaled clock
      pre_d = pre_q + 8'h01;
      if (tick) begin
        duty_irq_d = duty_hit;
        cca_irq_d  = cca_hit;
        ccb_irq_d  = ccb_hit;
        if (cyc_hit) begin
          cnt_d     = CNT_RST;
          cyc_irq_d = 1'b1;
          started_d = 1'b1;
          out_d     = ~inv;
        end else begin
          cnt_d = cnt_q + 16'h0001;
          if (duty_hit && started_q) begin
            out_d = inv;
          end
        end
      end
    end else begin
      // up/down mode: only external events move the counter
      out_d = inv;
      if (ev) begin
        up_d      = ev_up;
        cca_irq_d = cca_hit;
        ccb_irq_d = ccb_hit;
        if (!variant_b) begin
          cyc_irq_d  = cyc_hit;
          duty_irq_d = duty_hit;
          if (ev_up) begin
            // reload never applies counting up
            if (cyc_hit && ctrl_q[CTRL_CLR_HI]) begin
              cnt_d = CNT_RST;
            end else begin
              cnt_d = cnt_q + 16'h0001;
            end
          end else if (ctrl_q[CTRL_RELOAD] && cnt_q == CNT_RST) begin
            cnt_d = cyc_q;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end else begin
          if (ev_up) begin
            cyc_irq_d = cyc_hit;
            cnt_d     = cyc_hit ? CNT_RST : cnt_q + 16'h0001;
          end else begin
            duty_irq_d = duty_hit;
            cnt_d      = duty_hit ? CNT_RST : cnt_q - 16'h0001;
          end
        end
      end
      // external clear wins over any count in the same cycle
      if (ext_clr) begin
        cnt_d = CNT_RST;
      end
    end
  end

  // register the counter group
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q      <= CNT_RST;
      pre_q      <= '0;
      started_q  <= 1'b0;
      out_q      <= 1'b0;
      up_q       <= 1'b1;
      cyc_irq_q  <= 1'b0;
      duty_irq_q <= 1'b0;
      cca_irq_q  <= 1'b0;
      ccb_irq_q  <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      pre_q      <= pre_d;
      started_q  <= started_d;
      out_q      <= out_d;
      up_q       <= up_d;
      cyc_irq_q  <= cyc_irq_d;
      duty_irq_q <= duty_irq_d;
      cca_irq_q  <= cca_irq_d;
      ccb_irq_q  <= ccb_irq_d;
    end
  end

  // register port: writes and read mux
  always_comb begin
    ctrl_d  = ctrl_q;
    mode_d  = mode_q;
    cyc_d   = cyc_q;
    duty_d  = duty_q;
    cca_d   = cca_q;
    ccb_d   = ccb_q;
    rdata_d = '0;
    if (wr) begin
      if (addr == OFS_CTRL) begin
        ctrl_d = wdata[CTRL_W-1:0];
      end else if (addr == OFS_MODE) begin
        mode_d = wdata[MODE_W-1:0];
      end else if (addr == OFS_CYCLE) begin
        cyc_d = wdata;
      end else if (addr == OFS_DUTY) begin
        duty_d = wdata;
      end else if (addr == OFS_CCA) begin
        cca_d = wdata;
      end else if (addr == OFS_CCB) begin
        ccb_d = wdata;
      end
    end
    if (rd) begin
      if (addr == OFS_CTRL) begin
        rdata_d = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
      end else if (addr == OFS_MODE) begin
        rdata_d = {{(DATA_W-MODE_W){1'b0}}, mode_q};
      end else if (addr == OFS_CYCLE) begin
        rdata_d = cyc_q;
      end else if (addr == OFS_DUTY) begin
        rdata_d = duty_q;
      end else if (addr == OFS_CCA) begin
        rdata_d = cca_q;
      end else if (addr == OFS_CCB) begin
        rdata_d = ccb_q;
      end else if (addr == OFS_COUNT) begin
        rdata_d = cnt_q;
      end else if (addr == OFS_STATUS) begin
        rdata_d = {14'h0000, started_q, ~up_q};
      end
    end
  end

  // register the register file
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q  <= CTRL_RST;
      mode_q  <= MODE_RST;
      cyc_q   <= CNT_RST;
      duty_q  <= CNT_RST;
      cca_q   <= CNT_RST;
      ccb_q   <= CNT_RST;
      rdata_q <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      mode_q  <= mode_d;
      cyc_q   <= cyc_d;
      duty_q  <= duty_d;
      cca_q   <= cca_d;
      ccb_q   <= ccb_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from flops
  assign rdata           = rdata_q;
  assign timer_out_pin   = out_q;
  assign cycle_match_irq = cyc_irq_q;
  assign duty_match_irq  = duty_irq_q;
  assign capcomp_a_irq   = cca_irq_q;
  assign capcomp_b_irq   = ccb_irq_q;

  // checks on the counter behaviour
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  udc_out_idle_a: assert property (ce && udc_mode |=> out_q == $past(inv))
    else $error("timer output not idle in up/down mode");
  presc_space_a: assert property (ce && !udc_mode && tick |=> !tick [*3])
    else $error("count clock faster than clock/4");
  cycle_clear_a: assert property (ce && !udc_mode && tick && cyc_hit
      |=> cnt_q == 16'h0000 && cyc_irq_q)
    else $error("cycle match did not clear and interrupt");
  duty_level_a: assert property (ce && !udc_mode && tick && duty_hit && !cyc_hit
      && started_q |=> out_q == inv)
    else $error("duty match did not set inactive level");
  first_cycle_a: assert property (!started_q |-> out_q == $past(inv))
    else $error("timer output active before second cycle");
  udc_hold_a: assert property (ce && udc_mode && !ev && !ext_clr |=> $stable(cnt_q))
    else $error("counter moved without an external event");
  mode1_down_a: assert property (ce && udc_mode && !variant_b && phase == PH_MODE1
      && pv && pin_lvl[1] && !ctrl_q[CTRL_RELOAD] && !ext_clr
      |=> cnt_q == $past(cnt_q) - 16'h0001)
    else $error("mode 1 did not count down on high direction");
  mode2_both_a: assert property (ce && udc_mode && phase == PH_MODE2 && pv && dv
      && !ext_clr |=> $stable(cnt_q))
    else $error("mode 2 counted on coincident edges");
  reload_zero_a: assert property (ce && udc_mode && !variant_b && ev && !ev_up
      && ctrl_q[CTRL_RELOAD] && cnt_q == 16'h0000 && !ext_clr
      |=> cnt_q == $past(cyc_q))
    else $error("reload at zero counting down missed");
  varb_cycle_a: assert property (ce && udc_mode && variant_b && ev && ev_up && cyc_hit
      |=> cnt_q == 16'h0000 && cyc_irq_q)
    else $error("variant B up match did not clear");
  varb_duty_a: assert property (ce && udc_mode && variant_b && ev && ev_up
      |=> !duty_irq_q)
    else $error("variant B duty interrupt while counting up");
endmodule : udc_counter

// ==== hdl/udc_pkg.sv ====
// package: register map, field positions, reset values and mode codes
// assumes: one 100 MHz clock, registers reached over a plain strobe port
package udc_pkg;

  // register port shape
  localparam int unsigned ADDR_W     = 4;   // register address width
  localparam int unsigned DATA_W     = 16;  // register data width
  localparam int unsigned CNT_W      = 16;  // counter resolution
  localparam int unsigned CTRL_W     = 10;  // width of counter_control_reg
  localparam int unsigned MODE_W     = 8;   // width of counter_mode_reg
  localparam int unsigned PRESC_W    = 8;   // prescaler width, largest divide is 256
  localparam int unsigned SEL_W      = 3;   // prescale select width

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0; // counter_control_reg
  localparam logic [ADDR_W-1:0] OFS_MODE   = 4'h1; // counter_mode_reg
  localparam logic [ADDR_W-1:0] OFS_CYCLE  = 4'h2; // cycle_compare
  localparam logic [ADDR_W-1:0] OFS_DUTY   = 4'h3; // duty_compare
  localparam logic [ADDR_W-1:0] OFS_CCA    = 4'h4; // capcomp_a
  localparam logic [ADDR_W-1:0] OFS_CCB    = 4'h5; // capcomp_b
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'h6; // updown_counter, read only
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h7; // status, read only

  // counter_control_reg fields
  localparam int unsigned CTRL_CE      = 0; // count_enable_bit
  localparam int unsigned CTRL_RELOAD  = 1; // reload_enable
  localparam int unsigned CTRL_CLR_LO  = 2; // clear_source_lo: external clear enable
  localparam int unsigned CTRL_CLR_HI  = 3; // clear_source_hi: match clear enable
  localparam int unsigned CTRL_SEL_LSB = 4; // prescale select, 3 bits
  localparam int unsigned CTRL_CCA_CMP = 7; // capcomp_a in compare mode
  localparam int unsigned CTRL_CCB_CMP = 8; // capcomp_b in compare mode

  // counter_mode_reg fields
  localparam int unsigned MODE_UDC     = 0; // counting_mode_select
  localparam int unsigned MODE_VAR     = 1; // variant_select
  localparam int unsigned MODE_INV     = 2; // output_level_invert
  localparam int unsigned MODE_PH_LSB  = 3; // phase_mode_bit0..bit2
  localparam int unsigned MODE_PFALL   = 6; // pulse_input valid edge is falling
  localparam int unsigned MODE_DFALL   = 7; // direction_input valid edge is falling

  // status fields
  localparam int unsigned STAT_DOWN    = 0; // last count was downward
  localparam int unsigned STAT_STARTED = 1; // timer output waveform running

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;

  // phase mode codes
  localparam logic [2:0] PH_MODE1 = 3'h4; // pulse edge, direction by level
  localparam logic [2:0] PH_MODE2 = 3'h5; // up on pulse edge, down on direction edge
  localparam logic [2:0] PH_MODE3 = 3'h6; // pulse edge, direction sampled
  localparam logic [2:0] PH_MODE4 = 3'h7; // quadrature x4

  // prescaler: smallest divide is 4, each select step up to 6 doubles it; select 7 stays at 256
  localparam logic [PRESC_W:0] PRESC_BASE = 9'h004;

endpackage : udc_pkg

// ==== hdl/udc_sync.sv ====
// two-flop synchroniser with edge detection for a group of pin inputs
// assumes: inputs are asynchronous to clock; outputs are clock domain
`timescale 1ns/10ps
module udc_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  logic [W-1:0] meta_q;  // first stage, read only by the second
  logic [W-1:0] sync_q;  // second stage, safe level
  logic [W-1:0] prev_q;  // level one cycle ago
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_d;
  logic [W-1:0] prev_d;

  // next values of the chain
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // register the chain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // edges compare the two safe stages only
  assign lvl  = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;

endmodule : udc_sync

// ==== verification/test_updown_counter_timer_output.sv ====
// bench: counting modes, reload, clear and timer output of udc_counter
// assumes: udc_encoder_model drives the pins, registers over strobe port
`timescale 1ns/10ps
module test_updown_counter_timer_output;
  import udc_pkg::*;
  logic              clock = 1'b0; // 100 MHz
  logic              rst   = 1'b1; // held 10 cycles
  logic [ADDR_W-1:0] addr  = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic              wr    = 1'b0;
  logic              rd    = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              pulse_input, direction_input, external_clear_input;
  logic              timer_out_pin, cycle_match_irq, duty_match_irq;
  logic              cca_irq, ccb_irq;
  int                bad_count   = 0;
  int                check_count = 0;
  int                cyc_hits    = 0; // cycle irq pulses seen
  int                duty_hits   = 0; // duty irq pulses seen
  int                cca_hits    = 0; // capcomp_a irq pulses seen
  int                ccb_hits    = 0; // capcomp_b irq pulses seen
  always #5 clock = ~clock;
  // count irq pulses
  always @(posedge clock) begin
    cyc_hits  <= cyc_hits + int'(cycle_match_irq === 1'b1);
    duty_hits <= duty_hits + int'(duty_match_irq === 1'b1);
    cca_hits  <= cca_hits + int'(cca_irq === 1'b1);
    ccb_hits  <= ccb_hits + int'(ccb_irq === 1'b1);
  end
  udc_encoder_model enc (.clock(clock), .pulse_input(pulse_input),
    .direction_input(direction_input), .external_clear_input(external_clear_input));
  udc_counter uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pulse_input(pulse_input), .direction_input(direction_input),
    .external_clear_input(external_clear_input), .timer_out_pin(timer_out_pin),
    .cycle_match_irq(cycle_match_irq), .duty_match_irq(duty_match_irq),
    .capcomp_a_irq(cca_irq), .capcomp_b_irq(ccb_irq));
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // compare one word
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle write strobe
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  // read the counter and compare
  task automatic cnt(input string what, input logic [15:0] exp);
    logic [15:0] v;
    rd_reg(OFS_COUNT, v);
    chk(what, exp, v);
  endtask : cnt
  // stop, park pins low, set mode, start
  task automatic udc_on(input logic [15:0] m, input logic [15:0] c);
    wr_reg(OFS_CTRL, 16'h0000);
    enc.move(1'b0, 1'b0);
    wr_reg(OFS_MODE, m);
    wr_reg(OFS_CTRL, c);
  endtask : udc_on
  // k rising pulse edges with direction level held
  task automatic pulses(input logic dir, input int k);
    repeat (k) begin
      enc.move(1'b0, dir);
      enc.move(1'b1, dir);
    end
  endtask : pulses
  // reset values and an unmapped place
  task automatic t_reset();
    logic [3:0] al[4] = '{OFS_CTRL, OFS_MODE, OFS_COUNT, 4'h8};
    logic [15:0] v;
    foreach (al[i]) begin
      rd_reg(al[i], v);
      chk("reset value", 16'h0000, v);
    end
  endtask : t_reset
  // mode 1: level of direction picks up or down
  task automatic t_mode1();
    udc_on(16'h0021, 16'h0001);
    repeat (100) @(posedge clock);
    cnt("no pin no count", 16'h0000);
    chk("out idle in updown", 16'h0000, 16'(timer_out_pin));
    pulses(1'b0, 3);
    cnt("mode1 up", 16'h0003);
    pulses(1'b1, 1);
    cnt("mode1 down", 16'h0002);
  endtask : t_mode1
  // mode 2: pulse edge up, direction edge down, both at once hold
  task automatic t_mode2();
    udc_on(16'h0029, 16'h0001);
    enc.move(1'b1, 1'b0);
    enc.move(1'b0, 1'b0);
    enc.move(1'b1, 1'b1);
    cnt("mode2 coincident", 16'h0001);
    enc.move(1'b0, 1'b0);
    enc.move(1'b0, 1'b1);
    cnt("mode2 down", 16'h0000);
  endtask : t_mode2
  // mode 3: sampled direction high up, low down
  task automatic t_mode3();
    udc_on(16'h0031, 16'h0001);
    pulses(1'b1, 2);
    pulses(1'b0, 1);
    cnt("mode3", 16'h0001);
  endtask : t_mode3
  // mode 4: one quadrature cycle gives four counts, edge settings set but ignored
  task automatic t_mode4();
    logic [15:0] v;
    udc_on(16'h00f9, 16'h0001);
    enc.move(1'b1, 1'b0);
    enc.move(1'b1, 1'b1);
    enc.move(1'b0, 1'b1);
    enc.move(1'b0, 1'b0);
    rd_reg(OFS_COUNT, v);
    chk("x4 count", 16'h0004, v);
    enc.move(1'b1, 1'b1);
    rd_reg(OFS_COUNT, v);
    chk("x4 coincident", 16'h0005, v);
  endtask : t_mode4
  // variant A: reload at zero down, match down decrements with irq, external clear
  task automatic t_reload();
    int h;
    wr_reg(OFS_CTRL, 16'h0000);
    wr_reg(OFS_CYCLE, 16'h0005);
    udc_on(16'h0021, 16'h0003);
    pulses(1'b0, 1);
    cnt("no reload up", 16'h0001);
    pulses(1'b1, 2);
    cnt("reload", 16'h0005);
    h = cyc_hits;
    pulses(1'b1, 1);
    cnt("match down", 16'h0004);
    chk("match down irq", 16'(h + 1), 16'(cyc_hits));
    wr_reg(OFS_CTRL, 16'h0007);
    enc.clear_pulse();
    cnt("external clear", 16'h0000);
    wr_reg(OFS_CTRL, 16'h000b);
    h = cyc_hits;
    pulses(1'b0, 6);
    cnt("match up clear", 16'h0000);
    chk("match up irq", 16'(h + 1), 16'(cyc_hits));
  endtask : t_reload
  // variant B: up clears at cycle, down clears at duty, capcomp compare irqs
  task automatic t_varb();
    int c0;
    int d0;
    int a0;
    int b0;
    wr_reg(OFS_CTRL, 16'h0000);
    wr_reg(OFS_CYCLE, 16'h0002);
    wr_reg(OFS_DUTY, 16'h0001);
    wr_reg(OFS_CCA, 16'h0001);
    wr_reg(OFS_CCB, 16'h0002);
    udc_on(16'h0023, 16'h0181);
    c0 = cyc_hits;
    d0 = duty_hits;
    a0 = cca_hits;
    b0 = ccb_hits;
    pulses(1'b0, 2);
    cnt("varb up past duty", 16'h0002);
    pulses(1'b0, 1);
    cnt("varb up match", 16'h0000);
    chk("varb cycle irq", 16'(c0 + 1), 16'(cyc_hits));
    pulses(1'b0, 2);
    pulses(1'b1, 1);
    cnt("varb down match", 16'h0001);
    chk("varb no down cycle irq", 16'(c0 + 1), 16'(cyc_hits));
    chk("varb no up duty irq", 16'(d0), 16'(duty_hits));
    pulses(1'b1, 1);
    cnt("varb down duty", 16'h0000);
    chk("varb duty irq", 16'(d0 + 1), 16'(duty_hits));
    chk("capcomp a irq", 16'(a0 + 3), 16'(cca_hits));
    chk("capcomp b irq", 16'(b0 + 2), 16'(ccb_hits));
    wr_reg(OFS_CTRL, 16'h0000);
  endtask : t_varb
  // timer mode /16, cycle 3, duty 1: period 64 clocks, high 32
  task automatic t_timer();
    int n;
    int hi;
    int h0;
    int d0;
    wr_reg(OFS_CTRL, 16'h0000);
    wr_reg(OFS_CYCLE, 16'h0003);
    wr_reg(OFS_DUTY, 16'h0001);
    wr_reg(OFS_MODE, 16'h0000);
    wr_reg(OFS_CTRL, 16'h0021);
    hi = 0;
    for (n = 0; n < 300 && cycle_match_irq !== 1'b1; n++) begin
      @(posedge clock);
      #1 hi += int'(timer_out_pin === 1'b1 && cycle_match_irq !== 1'b1);
    end
    if (n >= 300) begin
      bad_count++;
      end_of_test();
    end
    chk("first cycle idle", 16'h0000, 16'(hi));
    h0 = cyc_hits;
    d0 = duty_hits;
    hi = 0;
    for (n = 1; n <= 64; n++) begin
      @(posedge clock);
      #1 hi += int'(timer_out_pin === 1'b1);
    end
    chk("period irq", 16'h0001, 16'(cycle_match_irq));
    chk("one irq a period", 16'(h0 + 1), 16'(cyc_hits));
    chk("duty irq", 16'(d0 + 1), 16'(duty_hits));
    chk("high time", 16'd32, 16'(hi));
    wr_reg(OFS_CTRL, 16'h0000);
    wr_reg(OFS_MODE, 16'h0004);
    repeat (2) @(posedge clock);
    #1 chk("inverted idle", 16'h0001, 16'(timer_out_pin));
  endtask : t_timer
  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_mode1();
    t_mode2();
    t_mode3();
    t_mode4();
    t_reload();
    t_varb();
    t_timer();
    end_of_test();
  end
endmodule : test_updown_counter_timer_output

// ==== verification/udc_encoder_model.sv ====
// partner: pin source for the count inputs and the external clear pin
// assumes: paced by the bench clock, pins asynchronous to the block
`timescale 1ns/10ps
module udc_encoder_model (
  input  wire logic clock,
  output logic      pulse_input,
  output logic      direction_input,
  output logic      external_clear_input
);
  // pins start low
  initial begin
    pulse_input          = 1'b0;
    direction_input      = 1'b0;
    external_clear_input = 1'b0;
  end
  // set both count pins, then hold half of a 160 ns link period
  task automatic move(input logic a, input logic b);
    @(posedge clock);
    pulse_input     <= a;
    direction_input <= b;
    repeat (8) @(posedge clock);
  endtask : move
  // one high pulse on the clear pin, long enough to be synchronised
  task automatic clear_pulse();
    @(posedge clock);
    external_clear_input <= 1'b1;
    repeat (8) @(posedge clock);
    external_clear_input <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : clear_pulse
endmodule : udc_encoder_model
